// ==== backlight_ramp_fault_irq_pkg.sv ====
package backlight_ramp_fault_irq_pkg;

  // ==========================================================
  // Register offsets on the serial host bus
  localparam logic [7:0] POWER_RAMP_TIME_OFS = 8'h07;
  localparam logic [7:0] RUN_RAMP_TIME_OFS = 8'h08;
  localparam logic [7:0] IRQ_FLAGS_OFS = 8'h09;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0a;
  localparam logic [7:0] LED_FAULT_FLAGS_OFS = 8'h0b;

  // ==========================================================
  // Reset values
  localparam logic [7:0] POWER_RAMP_TIME_RST = 8'h00;
  localparam logic [7:0] RUN_RAMP_TIME_RST = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] LED_FAULT_FLAGS_RST = 8'h00;

  // ==========================================================
  // Field positions
  localparam int RAMP_HI_MSB = 5;
  localparam int RAMP_HI_LSB = 3;
  localparam int RAMP_LO_MSB = 2;
  localparam int RAMP_LO_LSB = 0;
  localparam int OVERCURRENT_BIT = 2;
  localparam int OVERVOLTAGE_BIT = 1;
  localparam int THERMAL_BIT = 0;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int OPEN_BIT = 5;
  localparam int STRING2_SHORT_BIT = 4;
  localparam int STRING1_SHORT_BIT = 3;
  localparam int SHORT_TEST_EN_BIT = 2;
  localparam int MFG_OV_SEEN_BIT = 1;
  localparam int MFG_OV_TEST_EN_BIT = 0;

  // ==========================================================
  // Bus address; value arbitrary
  localparam logic [6:0] DEVICE_ADDR = 7'h38;

  // ==========================================================
  // Ramp durations in microseconds, and cycle counts at 250 MHz
  localparam longint unsigned CLK_MHZ = 250;
  localparam longint unsigned T_START0_US = 4000;
  localparam longint unsigned T_FAST_US = 500;
  localparam longint unsigned T_STEP1_US = 261000;
  localparam longint unsigned T_STEP2_US = 522000;
  localparam longint unsigned T_STEP3_US = 1045000;
  localparam longint unsigned T_STEP4_US = 2091000;
  localparam longint unsigned T_STEP5_US = 4182000;
  localparam longint unsigned T_STEP6_US = 8364000;
  localparam longint unsigned T_STEP7_US = 16730000;
  localparam logic [31:0] CYC_START0 = 32'(T_START0_US * CLK_MHZ);
  localparam logic [31:0] CYC_FAST = 32'(T_FAST_US * CLK_MHZ);
  localparam logic [223:0] CYC_STEPS = {
    32'(T_STEP7_US * CLK_MHZ), 32'(T_STEP6_US * CLK_MHZ), 32'(T_STEP5_US * CLK_MHZ),
    32'(T_STEP4_US * CLK_MHZ), 32'(T_STEP3_US * CLK_MHZ), 32'(T_STEP2_US * CLK_MHZ),
    32'(T_STEP1_US * CLK_MHZ)};

  // ==========================================================
  // Bus slave states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR = 4'h3,
    ST_PTR_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } bus_state_t;

endpackage : backlight_ramp_fault_irq_pkg

// ==== ramp_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ramp_timer #(
  parameter logic [31:0] ZERO_CYC = 32'h0000_0001,
  parameter logic [223:0] STEP_CYC = {7{32'h0000_0001}}
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic [2:0] code_in,
  output logic active_out,
  output logic done_out
);

  logic [31:0] duration;
  logic [31:0] count_reg;

  // Code zero is the short case, others step up by doubling
  always_comb begin
    if (code_in == 3'h0) begin
      duration = ZERO_CYC;
    end else begin
      duration = STEP_CYC[32 * (int'(code_in) - 1) +: 32];
    end
  end

  // Restart while busy reloads, so the newest request sets the length
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      count_reg <= 32'h0000_0000;
      active_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count_reg <= duration - 32'h0000_0001;
        active_out <= 1'b1;
      end else if (active_out) begin
        if (count_reg == 32'h0000_0000) begin
          active_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count_reg <= count_reg - 32'h0000_0001;
        end
      end
    end
  end

endmodule : ramp_timer
`default_nettype wire

// ==== backlight_ramp_fault_irq.sv ====
// Operation
// - Startup ramp code 0 gives 4 ms, codes 1-7 give 261 ms to 16.73 s.
// - Shutdown code 0 gives about 0.5 ms; other codes match startup times.
// - Run ramp: ramp-up code bits 5:3, ramp-down code bits 2:0, top bits read-only.
// - Run ramp codes: 0 is 0.5 ms, 1-7 are 261 ms to 16.73 s.
// - Interrupt flags: overcurrent bit 2, overvoltage bit 1, thermal bit 0.
// - Reading the interrupt flags register clears all flags.
// - A fault still present after the clear sets its flag again.
// - In sleep, reading the interrupt flags register leaves them set.
// - A fault sets its flag only with its source enable and global enable.
// - Mask bit 7 is the global enable gating the interrupt pin.
// - Mask bits 2, 1, 0 enable overcurrent, overvoltage, thermal sources.
// - Fault register bit 5 flags an open circuit on either string.
// - Fault register bits 3 and 4 flag shorts on string one and two.
// - Writing one to fault register bit 2 enables the short test.
// - Writing one to fault register bit 0 enables the overvoltage test.
// - Fault register bit 1 records overvoltage during the overvoltage test.
// - Power ramp: startup code bits 5:3, shutdown code bits 2:0.
`timescale 1ns/1ps
`default_nettype none
module backlight_ramp_fault_irq
  import backlight_ramp_fault_irq_pkg::*;
#(
  parameter logic [31:0] START0_CYCLES = CYC_START0,
  parameter logic [31:0] FAST_CYCLES = CYC_FAST,
  parameter logic [223:0] STEP_CYCLES = CYC_STEPS
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic overcurrent_in,
  input wire logic overvoltage_in,
  input wire logic thermal_in,
  input wire logic open_string_in,
  input wire logic string1_short_in,
  input wire logic string2_short_in,
  input wire logic sleep_status_in,
  input wire logic power_on_ramp_in,
  input wire logic power_off_ramp_in,
  input wire logic run_up_ramp_in,
  input wire logic run_down_ramp_in,
  output logic power_on_active_out,
  output logic power_off_active_out,
  output logic run_up_active_out,
  output logic run_down_active_out,
  output logic short_test_enable_out,
  output logic mfg_overvoltage_test_enable_out,
  output logic irq_out_n
);

  // ==========================================================
  // Pin synchronisers
  logic [8:0] pin_raw;
  logic [8:0] pin_meta_reg;
  logic [8:0] pin_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;

  assign pin_raw = {scl_in, sda_in, sleep_status_in, open_string_in, string2_short_in,
                    string1_short_in, overcurrent_in, overvoltage_in, thermal_in};

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pin_meta_reg <= 9'h180;
      pin_sync_reg <= 9'h180;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      scl_d_reg <= pin_sync_reg[8];
      sda_d_reg <= pin_sync_reg[7];
    end
  end

  logic scl_s;
  logic sda_s;
  logic sleep_s;
  logic [2:0] fault_s;
  assign scl_s = pin_sync_reg[8];
  assign sda_s = pin_sync_reg[7];
  assign sleep_s = pin_sync_reg[6];
  assign fault_s = pin_sync_reg[2:0];

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // ==========================================================
  // Serial host bus slave
  bus_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic ack_seen_reg;
  logic wr_strobe_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic rd_strobe;
  logic [7:0] rd_data;

  // Read side effects fire when the byte is loaded for sending
  assign rd_strobe = scl_fall && ((state_reg == ST_ADDR_ACK && rw_reg) ||
                     (state_reg == ST_RDATA_ACK && ack_seen_reg));
  assign sda_out = 1'b0;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      sda_oe_out <= 1'b0;
      wr_strobe_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_strobe_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_ADDR || state_reg == ST_PTR || state_reg == ST_WDATA) begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (state_reg == ST_RDATA_ACK) begin
          ack_seen_reg <= !sda_s;
        end
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == DEVICE_ADDR) begin
                sda_oe_out <= 1'b1;
                rw_reg <= shift_reg[0];
                state_reg <= ST_ADDR_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_PTR: begin
            if (bit_cnt_reg == 4'h8) begin
              ptr_reg <= shift_reg;
              sda_oe_out <= 1'b1;
              state_reg <= ST_PTR_ACK;
            end
          end
          ST_WDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              wr_strobe_reg <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg <= ptr_reg + 8'h01;
              sda_oe_out <= 1'b1;
              state_reg <= ST_WDATA_ACK;
            end
          end
          ST_ADDR_ACK, ST_RDATA_ACK: begin
            if (rd_strobe) begin
              tx_reg <= rd_data;
              ptr_reg <= ptr_reg + 8'h01;
              sda_oe_out <= !rd_data[7];
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RDATA;
            end else if (state_reg == ST_ADDR_ACK) begin
              sda_oe_out <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_PTR;
            end else begin
              sda_oe_out <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            sda_oe_out <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_out <= 1'b0;
              state_reg <= ST_RDATA_ACK;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_out <= !tx_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Ramp time registers
  logic [5:0] power_ramp_reg;
  logic [5:0] run_ramp_reg;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      power_ramp_reg <= POWER_RAMP_TIME_RST[5:0];
      run_ramp_reg <= RUN_RAMP_TIME_RST[5:0];
    end else if (wr_strobe_reg) begin
      if (wr_addr_reg == POWER_RAMP_TIME_OFS) begin
        power_ramp_reg <= wr_data_reg[RAMP_HI_MSB:RAMP_LO_LSB];
      end
      if (wr_addr_reg == RUN_RAMP_TIME_OFS) begin
        run_ramp_reg <= wr_data_reg[RAMP_HI_MSB:RAMP_LO_LSB];
      end
    end
  end

  logic [3:0] ramp_start;
  logic [11:0] ramp_code;
  logic [3:0] ramp_active;
  assign ramp_start = {run_down_ramp_in, run_up_ramp_in, power_off_ramp_in, power_on_ramp_in};
  assign ramp_code = {run_ramp_reg[RAMP_LO_MSB:RAMP_LO_LSB], run_ramp_reg[RAMP_HI_MSB:RAMP_HI_LSB],
                      power_ramp_reg[RAMP_LO_MSB:RAMP_LO_LSB],
                      power_ramp_reg[RAMP_HI_MSB:RAMP_HI_LSB]};

  // Only the startup ramp has its own long code-zero time
  generate
    for (genvar g = 0; g < 4; g++) begin : g_ramp
      ramp_timer #(
        .ZERO_CYC((g == 0) ? START0_CYCLES : FAST_CYCLES),
        .STEP_CYC(STEP_CYCLES)
      ) u_ramp (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .start_in(ramp_start[g]),
        .code_in(ramp_code[3 * g +: 3]),
        .active_out(ramp_active[g]),
        .done_out()
      );
    end
  endgenerate

  assign power_on_active_out = ramp_active[0];
  assign power_off_active_out = ramp_active[1];
  assign run_up_active_out = ramp_active[2];
  assign run_down_active_out = ramp_active[3];

  // ==========================================================
  // Interrupt flags and mask
  logic [2:0] irq_flags_reg;
  logic [2:0] irq_en_reg;
  logic global_en_reg;
  logic [2:0] flag_set;
  logic flag_clear;

  assign flag_set = fault_s & irq_en_reg & {3{global_en_reg}};
  assign flag_clear = rd_strobe && ptr_reg == IRQ_FLAGS_OFS && !sleep_s;

  // Set wins over the read clear, so a lasting fault comes straight back
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      irq_flags_reg <= IRQ_FLAGS_RST[2:0];
    end else begin
      irq_flags_reg <= (flag_clear ? 3'h0 : irq_flags_reg) | flag_set;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      irq_en_reg <= IRQ_MASK_RST[2:0];
      global_en_reg <= IRQ_MASK_RST[GLOBAL_EN_BIT];
    end else if (wr_strobe_reg && wr_addr_reg == IRQ_MASK_OFS) begin
      irq_en_reg <= wr_data_reg[OVERCURRENT_BIT:THERMAL_BIT];
      global_en_reg <= wr_data_reg[GLOBAL_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !(global_en_reg && |(irq_flags_reg & irq_en_reg));
    end
  end

  // ==========================================================
  // LED string fault flags and test enables
  logic [2:0] string_fault_reg;
  logic [2:0] string_fault_s;
  logic mfg_ov_seen_reg;
  assign string_fault_s = pin_sync_reg[5:3];

  // Detectors set their bits; a host write may clear them
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      string_fault_reg <= LED_FAULT_FLAGS_RST[OPEN_BIT:STRING1_SHORT_BIT];
      mfg_ov_seen_reg <= LED_FAULT_FLAGS_RST[MFG_OV_SEEN_BIT];
      short_test_enable_out <= LED_FAULT_FLAGS_RST[SHORT_TEST_EN_BIT];
      mfg_overvoltage_test_enable_out <= LED_FAULT_FLAGS_RST[MFG_OV_TEST_EN_BIT];
    end else begin
      if (wr_strobe_reg && wr_addr_reg == LED_FAULT_FLAGS_OFS) begin
        string_fault_reg <= wr_data_reg[OPEN_BIT:STRING1_SHORT_BIT] | string_fault_s;
        mfg_ov_seen_reg <= wr_data_reg[MFG_OV_SEEN_BIT] |
                           (fault_s[OVERVOLTAGE_BIT] & mfg_overvoltage_test_enable_out);
        short_test_enable_out <= wr_data_reg[SHORT_TEST_EN_BIT];
        mfg_overvoltage_test_enable_out <= wr_data_reg[MFG_OV_TEST_EN_BIT];
      end else begin
        string_fault_reg <= string_fault_reg | string_fault_s;
        mfg_ov_seen_reg <= mfg_ov_seen_reg |
                           (fault_s[OVERVOLTAGE_BIT] & mfg_overvoltage_test_enable_out);
      end
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    case (ptr_reg)
      POWER_RAMP_TIME_OFS: rd_data = {2'h0, power_ramp_reg};
      RUN_RAMP_TIME_OFS: rd_data = {2'h0, run_ramp_reg};
      IRQ_FLAGS_OFS: rd_data = {5'h00, irq_flags_reg};
      IRQ_MASK_OFS: rd_data = {global_en_reg, 4'h0, irq_en_reg};
      LED_FAULT_FLAGS_OFS: rd_data = {2'h0, string_fault_reg, short_test_enable_out,
                                      mfg_ov_seen_reg, mfg_overvoltage_test_enable_out};
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Checks
  irq_pin_track_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ##1 irq_out_n == !($past(global_en_reg) && |($past(irq_flags_reg) & $past(irq_en_reg))))
    else $error("interrupt pin does not follow enabled flags");

  global_gate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !global_en_reg [*2] |-> irq_out_n)
    else $error("interrupt pin asserted with global enable off");

  flag_set_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (global_en_reg && irq_en_reg[OVERCURRENT_BIT] && fault_s[OVERCURRENT_BIT])
    |=> irq_flags_reg[OVERCURRENT_BIT])
    else $error("enabled overcurrent fault did not set its flag");

  flag_gated_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(irq_flags_reg[THERMAL_BIT]) |-> $past(global_en_reg && irq_en_reg[THERMAL_BIT]))
    else $error("thermal flag set while its source was disabled");

  read_clear_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (rd_strobe && ptr_reg == IRQ_FLAGS_OFS && !sleep_s && flag_set == 3'h0)
    |=> irq_flags_reg == 3'h0)
    else $error("status read did not clear the flags");

  sleep_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (rd_strobe && ptr_reg == IRQ_FLAGS_OFS && sleep_s) |=> irq_flags_reg == $past(irq_flags_reg)
    || irq_flags_reg == ($past(irq_flags_reg) | $past(flag_set)))
    else $error("status read in sleep cleared the flags");

  refire_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (flag_clear && flag_set[OVERCURRENT_BIT]) |=> irq_flags_reg[OVERCURRENT_BIT] ##1 !irq_out_n)
    else $error("persisting fault lost at clear");

  open_flag_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    string_fault_s[2] |=> string_fault_reg[2])
    else $error("open string not recorded");

  mfg_seen_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (fault_s[OVERVOLTAGE_BIT] && mfg_overvoltage_test_enable_out) |=> mfg_ov_seen_reg)
    else $error("overvoltage in manufacturing test not recorded");

endmodule : backlight_ramp_fault_irq
`default_nettype wire

// ==== host_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial host master
// Four-clock quarter phases keep both SCL phases above the minimum.
module host_bus_model
  import backlight_ramp_fault_irq_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_drive_out
);
  initial begin
    scl_out = 1'b1;
    sda_drive_out = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : tick

  task automatic phase(input logic c, input logic d, input int n);
    scl_out <= c;
    sda_drive_out <= d;
    tick(n);
  endtask : phase

  task automatic put_bit(input logic b);
    phase(1'b0, b, 4);
    phase(1'b1, b, 8);
    phase(1'b0, b, 4);
  endtask : put_bit

  // Sampled mid-high: the device moves SDA only after SCL falls
  task automatic get_bit(output logic b);
    phase(1'b0, 1'b1, 4);
    phase(1'b1, 1'b1, 4);
    b = sda_in;
    phase(1'b1, 1'b1, 4);
    phase(1'b0, 1'b1, 4);
  endtask : get_bit

  task automatic start_bit;
    phase(1'b0, 1'b1, 4);
    phase(1'b1, 1'b1, 8);
    phase(1'b1, 1'b0, 8);
    phase(1'b0, 1'b0, 4);
  endtask : start_bit

  task automatic send_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
  endtask : send_byte

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start_bit();
    send_byte({DEVICE_ADDR, 1'b0});
    send_byte(a);
    send_byte(d);
    phase(1'b0, 1'b0, 4);
    phase(1'b1, 1'b0, 8);
    phase(1'b1, 1'b1, 8);
  endtask : write_reg

  // Single byte read, ended by a NACK
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    start_bit();
    send_byte({DEVICE_ADDR, 1'b0});
    send_byte(a);
    start_bit();
    send_byte({DEVICE_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    phase(1'b0, 1'b0, 4);
    phase(1'b1, 1'b0, 8);
    phase(1'b1, 1'b1, 8);
  endtask : read_reg
endmodule : host_bus_model
`default_nettype wire

// ==== test_backlight_ramp_fault_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_backlight_ramp_fault_irq;
  import backlight_ramp_fault_irq_pkg::*;
  // ==========================================================
  // Shortened ramp counts, each code a distinct length
  localparam logic [31:0] START0 = 32'h0c;
  localparam logic [31:0] FAST = 32'h05;
  localparam logic [223:0] STEPS = {32'h46, 32'h3c, 32'h32, 32'h28, 32'h1e, 32'h14, 32'h0a};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sleep;
  logic [2:0] fault;
  logic [2:0] det;
  logic [3:0] go;
  logic [7:0] rd;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  wire logic scl, host_sda, sda_o, sda_oe, short_en, ov_en, irq_n, sda_line;
  wire logic [3:0] act;
  // Pull-up: a released line reads high
  assign sda_line = host_sda & ~(sda_oe & ~sda_o);
  always #2 clk = ~clk;

  host_bus_model host (.sys_clk_in(clk), .sda_in(sda_line), .scl_out(scl),
    .sda_drive_out(host_sda));
  backlight_ramp_fault_irq #(.START0_CYCLES(START0), .FAST_CYCLES(FAST), .STEP_CYCLES(STEPS)) dut (
    .sys_clk_in(clk), .reset_in(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .overcurrent_in(fault[2]), .overvoltage_in(fault[1]),
    .thermal_in(fault[0]), .open_string_in(det[0]), .string1_short_in(det[1]),
    .string2_short_in(det[2]), .sleep_status_in(sleep), .power_on_ramp_in(go[0]),
    .power_off_ramp_in(go[1]), .run_up_ramp_in(go[2]), .run_down_ramp_in(go[3]),
    .power_on_active_out(act[0]), .power_off_active_out(act[1]),
    .run_up_active_out(act[2]), .run_down_active_out(act[3]),
    .short_test_enable_out(short_en), .mfg_overvoltage_test_enable_out(ov_en),
    .irq_out_n(irq_n));

  // ==========================================================
  // Shared tasks
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rd);
    check($sformatf("register %h", a), exp, rd);
  endtask : rchk

  function automatic logic [7:0] dur(input int c, input logic [31:0] z);
    return 8'((c == 0) ? z : STEPS[32 * (c - 1) +: 32]);
  endfunction : dur

  task automatic ramp_len(input int k, input logic [7:0] exp);
    int n;
    n = 0;
    go[k] <= 1'b1;
    @(posedge clk);
    go[k] <= 1'b0;
    @(posedge clk);
    while (act[k] === 1'b1 && n < 300) begin
      n++;
      @(posedge clk);
    end
    check($sformatf("ramp %0d length", k), exp, 8'(n));
  endtask : ramp_len

  // ==========================================================
  // Scenarios
  task automatic reg_access;
    for (int a = 7; a < 13; a++) rchk(8'(a), 8'h00);
    host.write_reg(POWER_RAMP_TIME_OFS, 8'hff);
    host.write_reg(RUN_RAMP_TIME_OFS, 8'hff);
    host.write_reg(IRQ_MASK_OFS, 8'hff);
    host.write_reg(8'h0c, 8'hff);
    rchk(POWER_RAMP_TIME_OFS, 8'h3f);
    rchk(RUN_RAMP_TIME_OFS, 8'h3f);
    rchk(IRQ_MASK_OFS, 8'h87);
    rchk(8'h0c, 8'h00);
  endtask : reg_access

  // Low field gets the mirrored code so swapped fields show up
  task automatic ramp_codes;
    for (int c = 0; c < 8; c++) begin
      host.write_reg(POWER_RAMP_TIME_OFS, 8'(c * 8 + 7 - c));
      host.write_reg(RUN_RAMP_TIME_OFS, 8'(c * 8 + 7 - c));
      ramp_len(0, dur(c, START0));
      ramp_len(1, dur(7 - c, FAST));
      ramp_len(2, dur(c, FAST));
      ramp_len(3, dur(7 - c, FAST));
    end
  endtask : ramp_codes

  task automatic irq_gating;
    host.write_reg(IRQ_MASK_OFS, 8'h07);
    fault <= 3'h4;
    host.tick(8);
    check("irq pin", 8'h01, {7'h0, irq_n});
    rchk(IRQ_FLAGS_OFS, 8'h00);
    host.write_reg(IRQ_MASK_OFS, 8'h87);
    host.tick(8);
    check("irq pin", 8'h00, {7'h0, irq_n});
    rchk(IRQ_FLAGS_OFS, 8'h04);
    rchk(IRQ_FLAGS_OFS, 8'h04);
    check("irq pin", 8'h00, {7'h0, irq_n});
    fault <= 3'h0;
    host.tick(8);
    rchk(IRQ_FLAGS_OFS, 8'h04);
    rchk(IRQ_FLAGS_OFS, 8'h00);
    check("irq pin", 8'h01, {7'h0, irq_n});
    for (int b = 0; b < 3; b++) begin
      fault <= 3'(1 << b);
      host.tick(8);
      fault <= 3'h0;
      host.tick(8);
      rchk(IRQ_FLAGS_OFS, 8'(1 << b));
    end
  endtask : irq_gating

  task automatic sleep_hold;
    fault <= 3'h1;
    host.tick(8);
    fault <= 3'h0;
    sleep <= 1'b1;
    host.tick(8);
    rchk(IRQ_FLAGS_OFS, 8'h01);
    rchk(IRQ_FLAGS_OFS, 8'h01);
    host.write_reg(IRQ_MASK_OFS, 8'h80);
    host.tick(8);
    check("irq pin", 8'h01, {7'h0, irq_n});
    sleep <= 1'b0;
    host.tick(8);
    rchk(IRQ_FLAGS_OFS, 8'h01);
    rchk(IRQ_FLAGS_OFS, 8'h00);
  endtask : sleep_hold

  task automatic fault_flags;
    logic [7:0] fexp [3] = '{8'h20, 8'h28, 8'h38};
    for (int d = 0; d < 3; d++) begin
      det <= 3'(1 << d);
      host.tick(8);
      det <= 3'h0;
      host.tick(8);
      rchk(LED_FAULT_FLAGS_OFS, fexp[d]);
    end
    host.write_reg(LED_FAULT_FLAGS_OFS, 8'h05);
    host.tick(8);
    check("short test", 8'h01, {7'h0, short_en});
    check("overvoltage test", 8'h01, {7'h0, ov_en});
    rchk(LED_FAULT_FLAGS_OFS, 8'h05);
    fault <= 3'h2;
    host.tick(8);
    fault <= 3'h0;
    host.tick(8);
    rchk(LED_FAULT_FLAGS_OFS, 8'h07);
  endtask : fault_flags

  // ==========================================================
  // Run control; the ceiling leaves over two and a half times the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fail_count = fail_count + 1;
      print_verdict();
    end
  end

  initial begin
    sleep <= 1'b0;
    fault <= 3'h0;
    det <= 3'h0;
    go <= 4'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq pin", 8'h01, {7'h0, irq_n});
    reg_access();
    ramp_codes();
    irq_gating();
    sleep_hold();
    fault_flags();
    print_verdict();
  end
endmodule : test_backlight_ramp_fault_irq
`default_nettype wire
